// ===== design/cfgsr_pkg.sv
// Constants shared by the configurable shift register design
package cfgsr_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned DEF_REGISTER_WIDTH = 8;
    localparam int unsigned ADDR_W             = 8;
    localparam int unsigned BUF_DEPTH          = 2;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CONFIG       = 8'h00;
    localparam logic [7:0] OFF_ASYNC_CLEAR  = 8'h04;
    localparam logic [7:0] OFF_SYNC_CLEAR   = 8'h08;
    localparam logic [7:0] OFF_ASYNC_PRESET = 8'h0C;
    localparam logic [7:0] OFF_SYNC_PRESET  = 8'h10;
    localparam logic [7:0] OFF_STATE        = 8'h14;
    localparam logic [7:0] OFF_STATUS       = 8'h18;

    // ==========================================================
    // Field positions
    localparam int unsigned CFG_EDGE_BIT     = 0;
    localparam int unsigned CFG_DIR_BIT      = 1;
    localparam int unsigned CFG_LOAD_BIT     = 2;
    localparam int unsigned CFG_POL_BIT      = 3;
    localparam int unsigned STAT_OVERRUN_BIT = 0;
    localparam int unsigned STAT_FULL_BIT    = 1;

    // ==========================================================
    // Encodings and reset values
    localparam logic        EDGE_0_TO_1        = 1'b0;
    localparam logic        EDGE_1_TO_0        = 1'b1;
    localparam logic [3:0]  CONFIG_RST         = 4'hE;
    localparam logic [31:0] ASYNC_CLEAR_RST    = 32'h0000_0000;
    localparam logic [31:0] SYNC_CLEAR_RST     = 32'h0000_0000;
    localparam logic [31:0] ASYNC_PRESET_RST   = 32'hFFFF_FFFF;
    localparam logic [31:0] SYNC_PRESET_RST    = 32'hFFFF_FFFF;
    localparam logic [31:0] STARTUP_RST        = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY          = 2'h0;
    localparam logic [1:0]  RESP_SLVERR        = 2'h2;

endpackage : cfgsr_pkg

// ===== design/cfgsr_stream_if.sv
// Valid/ready word stream between the shift core and its buffer
`timescale 1ns/1ps
`default_nettype none

interface cfgsr_stream_if #(parameter int unsigned W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : cfgsr_stream_if

`default_nettype wire

// ===== design/cfgsr_word_buffer.sv
// Two-entry buffer for register values, head slot drives the output
`timescale 1ns/1ps
`default_nettype none

module cfgsr_word_buffer #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic     aclk,
    input  wire logic     aresetn,
    // Streams
    cfgsr_stream_if.snk   in_s,
    cfgsr_stream_if.src   out_s
);

    logic [W-1:0] slot_q [cfgsr_pkg::BUF_DEPTH];
    logic [cfgsr_pkg::BUF_DEPTH-1:0] full_q;

    wire push = in_s.valid && in_s.ready;
    wire pop  = out_s.valid && out_s.ready;

    assign in_s.ready  = !full_q[1];
    assign out_s.valid = full_q[0];
    assign out_s.data  = slot_q[0];

    // ==========================================================
    // Slot 0 is the head; slot 1 only fills while slot 0 is held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            full_q    <= '0;
            slot_q[0] <= '0;
            slot_q[1] <= '0;
        end
        else if (push && pop)
        begin
            slot_q[0] <= full_q[1] ? slot_q[1] : in_s.data;
            slot_q[1] <= in_s.data;
        end
        else if (pop)
        begin
            slot_q[0] <= slot_q[1];
            full_q    <= {1'b0, full_q[1]};
        end
        else if (push)
        begin
            if (full_q[0])
                slot_q[1] <= in_s.data;
            else
                slot_q[0] <= in_s.data;
            full_q <= full_q[0] ? 2'h3 : 2'h1;
        end
    end

    // ==========================================================
    // Checks
    stall_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (full_q == 2'h3 && !out_s.ready) |=> (full_q == 2'h3 && !in_s.ready))
        else $error("buffer lost a word while stalled");

endmodule : cfgsr_word_buffer

`default_nettype wire

// ===== design/cfgsr_top.sv
// Configurable shift register with AXI4-Lite control and value stream
`timescale 1ns/1ps
`default_nettype none

module cfgsr_top #(
    parameter int unsigned                  register_width = cfgsr_pkg::DEF_REGISTER_WIDTH,
    parameter logic [register_width-1:0]    startup_value  = register_width'(cfgsr_pkg::STARTUP_RST)
) (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite write address
    input  wire logic                       awvalid,
    output var  logic                       awready,
    input  wire logic [cfgsr_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                 awprot,
    // AXI4-Lite write data and response
    input  wire logic                       wvalid,
    output var  logic                       wready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    output var  logic                       bvalid,
    input  wire logic                       bready,
    output var  logic [1:0]                 bresp,
    // AXI4-Lite read
    input  wire logic                       arvalid,
    output var  logic                       arready,
    input  wire logic [cfgsr_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                 arprot,
    output var  logic                       rvalid,
    input  wire logic                       rready,
    output var  logic [31:0]                rdata,
    output var  logic [1:0]                 rresp,
    // Shift controls
    input  wire logic                       shift_clk,
    input  wire logic                       shift_dir,
    input  wire logic                       load_shift,
    input  wire logic [register_width-1:0]  parallel_in,
    input  wire logic                       serial_fill_low,
    input  wire logic                       serial_fill_high,
    // Set and clear pins
    input  wire logic                       async_clear,
    input  wire logic                       async_preset,
    input  wire logic                       sync_clear,
    input  wire logic                       sync_preset,
    // Register outputs
    output var  logic [register_width-1:0]  q_out,
    output var  logic                       shift_out,
    // Value stream
    output var  logic                       word_valid,
    input  wire logic                       word_ready,
    output var  logic [register_width-1:0]  word_data
);

    localparam int unsigned W = register_width;

    // ==========================================================
    // Helpers
    function automatic logic is_active(input logic pin, input logic pol);
        return pin == pol;
    endfunction : is_active

    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        return r;
    endfunction : apply_strb

    // ==========================================================
    // Register state
    logic [3:0]   cfg_q;
    logic [W-1:0] async_clear_value_q;
    logic [W-1:0] sync_clear_value_q;
    logic [W-1:0] async_preset_value_q;
    logic [W-1:0] sync_preset_value_q;
    logic         overrun_q;

    // ==========================================================
    // AXI4-Lite slave state
    logic                          awready_q;
    logic                          wready_q;
    logic                          aw_held_q;
    logic                          w_held_q;
    logic [cfgsr_pkg::ADDR_W-1:0]  aw_addr_q;
    logic [31:0]                   w_data_q;
    logic [3:0]                    w_strb_q;
    logic                          bvalid_q;
    logic [1:0]                    bresp_q;
    logic                          arready_q;
    logic                          rvalid_q;
    logic [31:0]                   rdata_q;
    logic [1:0]                    rresp_q;

    wire aw_take  = awvalid && awready_q;
    wire w_take   = wvalid && wready_q;
    wire do_write = aw_held_q && w_held_q && !bvalid_q;
    wire aw_held_d = (aw_held_q || aw_take) && !do_write;
    wire w_held_d  = (w_held_q || w_take) && !do_write;
    wire ar_take  = arvalid && arready_q;
    wire rvalid_d = ar_take || (rvalid_q && !rready);

    // Write decode
    wire wr_cfg  = aw_addr_q == cfgsr_pkg::OFF_CONFIG;
    wire wr_acv  = aw_addr_q == cfgsr_pkg::OFF_ASYNC_CLEAR;
    wire wr_scv  = aw_addr_q == cfgsr_pkg::OFF_SYNC_CLEAR;
    wire wr_apv  = aw_addr_q == cfgsr_pkg::OFF_ASYNC_PRESET;
    wire wr_spv  = aw_addr_q == cfgsr_pkg::OFF_SYNC_PRESET;
    wire wr_st   = aw_addr_q == cfgsr_pkg::OFF_STATE;
    wire wr_stat = aw_addr_q == cfgsr_pkg::OFF_STATUS;
    wire wr_hit  = wr_cfg || wr_acv || wr_scv || wr_apv || wr_spv || wr_st || wr_stat;
    wire [31:0] cfg_wr = apply_strb(32'(cfg_q), w_data_q, w_strb_q);
    wire overrun_clr = do_write && wr_stat && w_strb_q[0] && w_data_q[cfgsr_pkg::STAT_OVERRUN_BIT];

    // ==========================================================
    // Shift core signals
    logic [W-1:0] q_q;
    logic         shift_out_q;
    logic         clk_prev_q;
    logic         armed_q;

    cfgsr_stream_if #(.W(W)) in_s ();
    cfgsr_stream_if #(.W(W)) out_s ();

    wire edge_fall  = cfg_q[cfgsr_pkg::CFG_EDGE_BIT] == cfgsr_pkg::EDGE_1_TO_0;
    wire setclr_pol = cfg_q[cfgsr_pkg::CFG_POL_BIT];
    wire clk_rise   = armed_q && !clk_prev_q && shift_clk;
    wire clk_fall   = armed_q && clk_prev_q && !shift_clk;
    wire shift_edge = edge_fall ? clk_fall : clk_rise;
    wire aclr_act   = is_active(async_clear, setclr_pol);
    wire apre_act   = is_active(async_preset, setclr_pol);
    wire sclr_act   = is_active(sync_clear, setclr_pol);
    wire spre_act   = is_active(sync_preset, setclr_pol);
    wire async_any  = aclr_act || apre_act;
    wire go_left    = shift_dir == cfg_q[cfgsr_pkg::CFG_DIR_BIT];
    wire do_load    = load_shift == cfg_q[cfgsr_pkg::CFG_LOAD_BIT];
    wire fire       = in_s.valid && in_s.ready;
    wire plain      = !sclr_act && !spre_act;
    wire do_shift   = fire && plain && !do_load;
    wire [W-1:0] left_v  = {q_q[W-2:0], serial_fill_low};
    wire [W-1:0] right_v = {serial_fill_high, q_q[W-1:1]};

    // Sync clear beats sync preset beats load or shift
    wire [W-1:0] edge_v = sclr_act ? sync_clear_value_q :
                          spre_act ? sync_preset_value_q :
                          do_load  ? parallel_in :
                          go_left  ? left_v : right_v;
    // Async clear beats async preset beats any clocked action
    wire [W-1:0] q_d = aclr_act ? async_clear_value_q :
                       apre_act ? async_preset_value_q :
                       fire     ? edge_v : q_q;
    wire shift_out_d = do_shift ? (go_left ? q_q[W-1] : q_q[0]) : shift_out_q;
    wire overrun_set = shift_edge && !async_any && !in_s.ready;

    assign in_s.valid  = shift_edge && !async_any;
    assign in_s.data   = edge_v;
    assign out_s.ready = word_ready;

    // Read decode
    wire rd_cfg  = araddr == cfgsr_pkg::OFF_CONFIG;
    wire rd_acv  = araddr == cfgsr_pkg::OFF_ASYNC_CLEAR;
    wire rd_scv  = araddr == cfgsr_pkg::OFF_SYNC_CLEAR;
    wire rd_apv  = araddr == cfgsr_pkg::OFF_ASYNC_PRESET;
    wire rd_spv  = araddr == cfgsr_pkg::OFF_SYNC_PRESET;
    wire rd_st   = araddr == cfgsr_pkg::OFF_STATE;
    wire rd_stat = araddr == cfgsr_pkg::OFF_STATUS;
    wire rd_hit  = rd_cfg || rd_acv || rd_scv || rd_apv || rd_spv || rd_st || rd_stat;
    wire [31:0] stat_word = 32'({!in_s.ready, overrun_q});
    wire [31:0] rd_word = rd_cfg  ? 32'(cfg_q) :
                          rd_acv  ? 32'(async_clear_value_q) :
                          rd_scv  ? 32'(sync_clear_value_q) :
                          rd_apv  ? 32'(async_preset_value_q) :
                          rd_spv  ? 32'(sync_preset_value_q) :
                          rd_st   ? 32'(q_q) :
                          rd_stat ? stat_word : 32'h0000_0000;

    cfgsr_word_buffer #(
        .W       (W)
    ) u_buffer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .in_s    (in_s),
        .out_s   (out_s)
    );

    // ==========================================================
    // Write channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end
        else
        begin
            awready_q <= !aw_held_d;
            wready_q  <= !w_held_d;
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            if (aw_take)
                aw_addr_q <= awaddr;
            if (w_take)
            begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= cfgsr_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? cfgsr_pkg::RESP_OKAY : cfgsr_pkg::RESP_SLVERR;
        end
        else if (bready)
            bvalid_q <= 1'b0;
    end

    // ==========================================================
    // Configuration and value registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_q                <= cfgsr_pkg::CONFIG_RST;
            async_clear_value_q  <= W'(cfgsr_pkg::ASYNC_CLEAR_RST);
            sync_clear_value_q   <= W'(cfgsr_pkg::SYNC_CLEAR_RST);
            async_preset_value_q <= W'(cfgsr_pkg::ASYNC_PRESET_RST);
            sync_preset_value_q  <= W'(cfgsr_pkg::SYNC_PRESET_RST);
        end
        else if (do_write)
        begin
            if (wr_cfg)
                cfg_q <= cfg_wr[3:0];
            if (wr_acv)
                async_clear_value_q <= W'(apply_strb(32'(async_clear_value_q), w_data_q, w_strb_q));
            if (wr_scv)
                sync_clear_value_q <= W'(apply_strb(32'(sync_clear_value_q), w_data_q, w_strb_q));
            if (wr_apv)
                async_preset_value_q <= W'(apply_strb(32'(async_preset_value_q), w_data_q, w_strb_q));
            if (wr_spv)
                sync_preset_value_q <= W'(apply_strb(32'(sync_preset_value_q), w_data_q, w_strb_q));
        end
    end

    // Lost edge flag: a new loss wins over a clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            overrun_q <= 1'b0;
        else
            overrun_q <= overrun_set || (overrun_q && !overrun_clr);
    end

    // ==========================================================
    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= cfgsr_pkg::RESP_OKAY;
        end
        else
        begin
            arready_q <= !rvalid_d;
            rvalid_q  <= rvalid_d;
            if (ar_take)
            begin
                rdata_q <= rd_word;
                rresp_q <= rd_hit ? cfgsr_pkg::RESP_OKAY : cfgsr_pkg::RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // Shift register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q_q         <= startup_value;
            shift_out_q <= 1'b0;
            clk_prev_q  <= 1'b0;
            armed_q     <= 1'b0;
        end
        else
        begin
            q_q         <= q_d;
            shift_out_q <= shift_out_d;
            clk_prev_q  <= shift_clk;
            armed_q     <= 1'b1;
        end
    end

    // ==========================================================
    // Outputs
    assign awready    = awready_q;
    assign wready     = wready_q;
    assign bvalid     = bvalid_q;
    assign bresp      = bresp_q;
    assign arready    = arready_q;
    assign rvalid     = rvalid_q;
    assign rdata      = rdata_q;
    assign rresp      = rresp_q;
    assign q_out      = q_q;
    assign shift_out  = shift_out_q;
    assign word_valid = out_s.valid;
    assign word_data  = out_s.data;

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence aclr_s;
        aclr_act;
    endsequence
    sequence apre_s;
        apre_act && !aclr_act;
    endsequence
    sequence fire_s;
        fire && !async_any;
    endsequence
    sequence wrong_edge_s;
        armed_q && !async_any && (shift_clk != clk_prev_q) && (shift_clk == edge_fall);
    endsequence

    startup_value_a: assert property (disable iff (1'b0) !aresetn |=> q_q == startup_value)
        else $error("register did not start from startup value");
    async_clear_a: assert property (aclr_s |=> q_q == $past(async_clear_value_q))
        else $error("async clear value not taken");
    async_preset_a: assert property (apre_s |=> q_q == $past(async_preset_value_q))
        else $error("async preset value not taken");
    clear_pin_level_a: assert property ((!setclr_pol && !async_clear) |=> q_q == $past(async_clear_value_q))
        else $error("clear pin polarity not honoured");
    sync_clear_a: assert property (fire_s and sclr_act |=> q_q == $past(sync_clear_value_q))
        else $error("sync clear value not taken");
    sync_preset_a: assert property (fire_s and (spre_act && !sclr_act) |=> q_q == $past(sync_preset_value_q))
        else $error("sync preset value not taken");
    sync_over_load_a: assert property (fire_s and (sclr_act && do_load)
                                       |=> q_q == $past(sync_clear_value_q))
        else $error("load beat sync clear");
    parallel_load_a: assert property (fire_s and (plain && do_load) |=> q_q == $past(parallel_in))
        else $error("parallel load missed");
    shift_left_a: assert property (fire_s and (plain && !do_load && go_left)
                                   |=> q_q == {$past(q_q[W-2:0]), $past(serial_fill_low)} &&
                                       shift_out_q == $past(q_q[W-1]))
        else $error("left shift wrong");
    shift_right_a: assert property (fire_s and (plain && !do_load && !go_left)
                                    |=> q_q == {$past(serial_fill_high), $past(q_q[W-1:1])} &&
                                        shift_out_q == $past(q_q[0]))
        else $error("right shift wrong");
    wrong_edge_a: assert property (wrong_edge_s |=> $stable(q_q) && $stable(shift_out_q))
        else $error("register moved on the wrong edge");
    edge_hold_a: assert property ((!shift_edge && !async_any) |=> $stable(q_q))
        else $error("register moved without an edge");
    stall_hold_a: assert property ((shift_edge && !async_any && !in_s.ready) |=> $stable(q_q) && overrun_q)
        else $error("stalled edge changed the register");
    write_resp_a: assert property ((aw_take && w_take) |=> ##1 bvalid_q)
        else $error("write response late");

endmodule : cfgsr_top

`default_nettype wire

// ===== verif/cfgsr_far_model.sv
// Far-side logic model: shift clock pulser and stream sink
`timescale 1ns/1ps
`default_nettype none
module cfgsr_far_model (
    // Clock
    input  wire logic aclk,
    // Commands from the bench
    input  wire logic step,
    input  wire logic stall,
    // Pins toward the register
    output var  logic shift_clk,
    output var  logic word_ready
);
    // One high cycle of shift clock per step, low between frames
    always_ff @(posedge aclk)
    begin
        shift_clk  <= step & ~shift_clk;
        word_ready <= ~stall;
    end
endmodule : cfgsr_far_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking testbench for the configurable shift register
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] START_V = 8'hA5;
    logic       aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, step, stall, shift_dir, load_shift;
    logic       serial_fill_low, serial_fill_high, async_clear, async_preset, sync_clear, sync_preset;
    logic       awready, wready, bvalid, arready, rvalid, shift_clk, shift_out, word_valid, word_ready;
    logic [7:0] awaddr, araddr, parallel_in, q_out, word_data;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    int         miscompares = 0;
    int         checks_done = 0;
    cfgsr_top #(.register_width(8), .startup_value(START_V)) DUT (.aclk, .aresetn, .awvalid, .awready,
        .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .shift_clk,
        .shift_dir, .load_shift, .parallel_in, .serial_fill_low, .serial_fill_high, .async_clear,
        .async_preset, .sync_clear, .sync_preset, .q_out, .shift_out, .word_valid, .word_ready, .word_data);
    cfgsr_far_model far (.aclk, .step, .stall, .shift_clk, .word_ready);
    // ==========================================
    // Shared tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_d = 1'b0;
        logic w_d = 1'b0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        while (!(aw_d && w_d))
        begin
            @(posedge aclk);
            aw_d = aw_d | awready;
            w_d = w_d | wready;
            if (aw_d) awvalid <= 1'b0;
            if (w_d) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (!bvalid);
        chk("bresp", 32'(cfgsr_pkg::RESP_OKAY), 32'(bresp));
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    task automatic pulse();
        step <= 1'b1;
        @(posedge aclk);
        step <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : pulse
    // ==========================================
    // Scenarios
    task automatic t_reset();
        chk("q_out startup", START_V, q_out);
        axi_rd(cfgsr_pkg::OFF_CONFIG);
        chk("config reset", 32'h0000_000E, rd);
        axi_rd(8'h1C);
        chk("unmapped resp", cfgsr_pkg::RESP_SLVERR, rs);
    endtask : t_reset
    task automatic t_load_shift();
        load_shift <= 1'b1;
        parallel_in <= 8'h3C;
        pulse();
        chk("load", 32'h3C, q_out);
        load_shift <= 1'b0;
        serial_fill_low <= 1'b1;
        pulse();
        chk("left shift", 32'h79, q_out);
        chk("left out", 32'h0, shift_out);
        shift_dir <= 1'b0;
        pulse();
        chk("right shift", 32'h3C, q_out);
        chk("right out", 32'h1, shift_out);
    endtask : t_load_shift
    task automatic t_sync();
        sync_preset <= 1'b1;
        load_shift <= 1'b1;
        pulse();
        chk("sync preset", 32'hFF, q_out);
        sync_preset <= 1'b0;
        sync_clear <= 1'b1;
        pulse();
        chk("sync clear", 32'h00, q_out);
        sync_clear <= 1'b0;
    endtask : t_sync
    task automatic t_async();
        axi_wr(cfgsr_pkg::OFF_ASYNC_CLEAR, 32'h5A);
        async_clear <= 1'b1;
        pulse();
        chk("async clear", 32'h5A, q_out);
        async_clear <= 1'b0;
        async_preset <= 1'b1;
        pulse();
        chk("async preset", 32'hFF, q_out);
        async_preset <= 1'b0;
        axi_wr(cfgsr_pkg::OFF_CONFIG, 32'h6);
        repeat (3) @(posedge aclk);
        chk("low active clear", 32'h5A, q_out);
        axi_wr(cfgsr_pkg::OFF_CONFIG, 32'hE);
    endtask : t_async
    task automatic t_buffer();
        stall <= 1'b1;
        repeat (3) pulse();
        axi_rd(cfgsr_pkg::OFF_STATUS);
        chk("full and overrun", 32'h3, rd);
        chk("head word valid", 32'h1, word_valid);
        chk("head word data", 32'h3C, word_data);
        stall <= 1'b0;
        repeat (4) @(posedge aclk);
        chk("buffer drained", 32'h0, word_valid);
        axi_wr(cfgsr_pkg::OFF_STATUS, 32'h1);
        axi_rd(cfgsr_pkg::OFF_STATUS);
        chk("overrun cleared", 32'h0, rd);
        axi_wr(cfgsr_pkg::OFF_CONFIG, 32'hF);
        parallel_in <= 8'hC3;
        pulse();
        chk("falling edge load", 32'hC3, q_out);
        axi_wr(cfgsr_pkg::OFF_CONFIG, 32'hE);
    endtask : t_buffer
    // ==========================================
    // Clock, reset, sequence and watchdog
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, step, stall, load_shift} = '0;
        {serial_fill_low, serial_fill_high, async_clear, async_preset, sync_clear, sync_preset} = '0;
        {awaddr, araddr, parallel_in, wdata} = '0;
        shift_dir = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_load_shift();
        t_sync();
        t_async();
        t_buffer();
        summarize();
    end
    initial
    begin
        #160000;
        miscompares++;
        summarize();
    end
endmodule : tb
`default_nettype wire
